// >>> rtl/mecs_defines.svh
`ifndef MECS_DEFINES_SVH
`define MECS_DEFINES_SVH
// register byte offsets
`define MECS_OFS_CFG 9'h020
`define MECS_OFS_THR 9'h024
`define MECS_OFS_GAIN 9'h040
`define MECS_OFS_STAT 9'h080
`define MECS_OFS_IRQ_ST 9'h100
`define MECS_OFS_IRQ_MSK 9'h104
`define MECS_OFS_HCNT 9'h108
`define MECS_OFS_HPW 9'h10C
`define MECS_OFS_HPR 9'h110
`define MECS_OFS_COEF 9'h114
// reset values and configuration write mask
`define MECS_RST_CFG 32'h0000_5020
`define MECS_RST_THR 32'h0006_C278
`define MECS_RST_GAIN 32'h0000_4000
`define MECS_CFG_WMASK 32'h000F_FFEF
// configuration word fields
`define MECS_CFG_SAGB 19
`define MECS_CFG_SAGA 18
`define MECS_CFG_SAGINT 17
`define MECS_CFG_EXTT 16
`define MECS_CFG_CNT_HI 15
`define MECS_CFG_CNT_LO 8
`define MECS_CFG_FS_HI 7
`define MECS_CFG_FS_LO 6
`define MECS_CFG_EXTP 5
`define MECS_CFG_BSH 3
`define MECS_CFG_ASH 2
`define MECS_CFG_FAST 1
`define MECS_CFG_SLOW 0
// status word fields
`define MECS_ST_F0 28
`define MECS_ST_SAGB 26
`define MECS_ST_SAGA 25
// interrupt bits
`define MECS_IRQ_SAG 0
`define MECS_IRQ_SAGA 1
`define MECS_IRQ_SAGB 2
// gains and shifts
`define MECS_PG_NORM 16'h0600
`define MECS_PG_FAST 16'h6000
`define MECS_PG_SLOW 16'h0018
`define MECS_FAST_SH 4
`define MECS_SLOW_SH 6
`define MECS_GAIN_X8 4'h8
`define MECS_GAIN_X1 4'h1
`define MECS_TC_SH 14
`endif

// >>> rtl/mecs_pkg.sv
package mecs_pkg;
  // avalon-mm request from the host side
  typedef struct packed {
    logic read;
    logic write;
    logic [8:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } mecs_avm_req_s;

  // per-phase sag detector state
  typedef struct packed {
    logic [7:0] cnt;
    logic flag;
  } mecs_sag_s;

  // top-level state
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] cfg;
    logic [31:0] thr;
    logic [31:0] gain;
    logic [31:0] hpw;
    logic [31:0] hpr;
    logic [31:0] coef;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
    logic irq;
    logic [15:0] hcnt;
    logic sq_d;
    logic comb_d;
    logic sag_a_d;
    logic sag_b_d;
    logic aux;
    logic sel_b;
    logic f0;
    logic [31:0] pw;
    logic [31:0] pr;
    logic [31:0] pv;
    logic [15:0] pgain;
    logic [3:0] ga;
    logic [3:0] gb;
  } mecs_top_s;
endpackage

// >>> rtl/mecs_sag_det.sv
`timescale 1ns/1ps
`include "mecs_defines.svh"
module mecs_sag_det import mecs_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic smp_valid,
  input wire logic [31:0] smp_mag,
  input wire logic [31:0] threshold,
  input wire logic [7:0] need_count,
  output logic sag_flag
);
  mecs_sag_s st_r;
  mecs_sag_s st_nxt;

  // count consecutive low samples; the counter saturates so 255 never wraps
  always_comb begin
    logic [7:0] inc;
    inc = (st_r.cnt == 8'hFF) ? st_r.cnt : st_r.cnt + 8'h01;
    st_nxt = st_r;
    if (smp_valid) begin
      if (smp_mag >= threshold) begin
        st_nxt.cnt = 8'h00;
        st_nxt.flag = 1'b0;
      end else begin
        st_nxt.cnt = inc;
        if (inc >= need_count) begin
          st_nxt.flag = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sag_flag = st_r.flag;

  chk_sag_clear: assert property (@(posedge core_clk) disable iff (rst)
    smp_valid && smp_mag >= threshold |=> !sag_flag && st_r.cnt == 8'h00)
    else $error("sag flag or counter not cleared by high sample");
  chk_sag_declare: assert property (@(posedge core_clk) disable iff (rst)
    smp_valid && smp_mag < threshold && st_r.cnt < 8'hFF
      && (st_r.cnt + 8'h01) >= need_count |=> sag_flag)
    else $error("sag not declared after enough low samples");
  chk_sag_early: assert property (@(posedge core_clk) disable iff (rst)
    !sag_flag && smp_valid && (st_r.cnt + 9'h001) < {1'b0, need_count} |=> !sag_flag)
    else $error("sag declared before the sample count");
endmodule // mecs_sag_det

// >>> rtl/mecs_top.sv
`timescale 1ns/1ps
`include "mecs_defines.svh"
// Contract
// - with host temperature compensation off, the engine updates the gain scale itself from the coefficients and the temperature offset.
// - with host temperature compensation on (bit 16), only the host writes the gain scale.
// - bits 7 and 6 pick the phase for the PLL, frequency, lag, half-cycle count and square flag; 00 is A, 01 is B.
// - bit 19 enables phase B and bit 18 phase A for sag interrupts, both reset to 0.
// - with several masks set, the sag interrupt is raised only while all enabled phases sag together.
// - bit 17 routes the sag interrupt onto the auxiliary pulse pin instead of its pulse function.
// - bits 15 to 8 hold the number of consecutive low samples that declares a sag, reset 0x50, max 255.
// - bit 5 at 0 feeds the pulse generators from internal sums, at 1 (reset) watt and var from host values and VA from zero.
// - bit 3 set gives current channel B a gain of 8, else 1.
// - bit 2 set gives current channel A a gain of 8, else 1.
// - the fast bit multiplies the pulse generator input by 16 and the slow bit divides it by 64.
// - the pulse gain factor is 6, 96 with fast only, 0.09375 with slow only; the host never sets both.
// - the sag threshold word at 0x24 resets to 443000.
// - each phase sag flag sets after the configured count of low samples and holds until the voltage rises.
// - the configuration word sits at 0x20 and resets to 0x5020.
module mecs_top import mecs_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire mecs_avm_req_s avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic smp_valid,
  input wire logic [31:0] va_mag,
  input wire logic [31:0] vb_mag,
  input wire logic va_square,
  input wire logic vb_square,
  input wire logic temp_valid,
  input wire logic signed [7:0] temp_delta,
  input wire logic [31:0] watt_sum,
  input wire logic [31:0] var_sum,
  input wire logic [31:0] va_sum,
  input wire logic aux_pulse_in,
  output logic aux_pulse_pin,
  output logic irq,
  output logic phase_sel_b,
  output logic fundamental_square_flag,
  output logic [31:0] gain_scale,
  output logic [31:0] pulse_watt_in,
  output logic [31:0] pulse_var_in,
  output logic [31:0] pulse_va_in,
  output logic [15:0] pulse_gain_q8,
  output logic [3:0] chan_a_gain,
  output logic [3:0] chan_b_gain
);
  mecs_top_s st_r;
  mecs_top_s st_nxt;
  logic sag_a;
  logic sag_b;
  logic sag_comb;
  logic req;
  logic accept;

  // one sag detector per phase, sharing threshold and count
  mecs_sag_det u_sag_a (
    .core_clk(core_clk),
    .rst(rst),
    .smp_valid(smp_valid),
    .smp_mag(va_mag),
    .threshold(st_r.thr),
    .need_count(st_r.cfg[`MECS_CFG_CNT_HI:`MECS_CFG_CNT_LO]),
    .sag_flag(sag_a)
  );
  mecs_sag_det u_sag_b (
    .core_clk(core_clk),
    .rst(rst),
    .smp_valid(smp_valid),
    .smp_mag(vb_mag),
    .threshold(st_r.thr),
    .need_count(st_r.cfg[`MECS_CFG_CNT_HI:`MECS_CFG_CNT_LO]),
    .sag_flag(sag_b)
  );

  // every enabled phase must sag at once; no mask means no interrupt
  assign sag_comb = (st_r.cfg[`MECS_CFG_SAGA] | st_r.cfg[`MECS_CFG_SAGB])
    & (~st_r.cfg[`MECS_CFG_SAGA] | sag_a)
    & (~st_r.cfg[`MECS_CFG_SAGB] | sag_b);

  // a request is taken on the edge where waitrequest is already low
  assign req = avm_req.read | avm_req.write;
  assign accept = req & ~st_r.waitreq;

  // merge write data into a word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // next-state logic
  always_comb begin
    logic sel_sq;
    logic [31:0] src_w;
    logic [31:0] src_r;
    logic [31:0] src_v;
    logic signed [15:0] lin;
    logic signed [15:0] quad;
    logic signed [23:0] p1;
    logic signed [15:0] sq;
    logic signed [31:0] p2;
    logic signed [32:0] corr;
    logic [2:0] ev;
    logic [31:0] rd;
    sel_sq = 1'b0;
    src_w = '0;
    src_r = '0;
    src_v = '0;
    lin = $signed(st_r.coef[15:0]);
    quad = $signed(st_r.coef[31:16]);
    p1 = '0;
    sq = '0;
    p2 = '0;
    corr = '0;
    ev = '0;
    rd = '0;
    st_nxt = st_r;

    // bus handshake: waitrequest drops for the one cycle after a request arrives
    st_nxt.waitreq = ~(req & st_r.waitreq);

    // read mux, latched while waitrequest is high so data stands at the taking edge
    if (avm_req.address == `MECS_OFS_CFG) begin
      rd = st_r.cfg;
    end else if (avm_req.address == `MECS_OFS_THR) begin
      rd = st_r.thr;
    end else if (avm_req.address == `MECS_OFS_GAIN) begin
      rd = st_r.gain;
    end else if (avm_req.address == `MECS_OFS_STAT) begin
      rd[`MECS_ST_F0] = st_r.f0;
      rd[`MECS_ST_SAGB] = sag_b;
      rd[`MECS_ST_SAGA] = sag_a;
    end else if (avm_req.address == `MECS_OFS_IRQ_ST) begin
      rd[2:0] = st_r.irq_st;
    end else if (avm_req.address == `MECS_OFS_IRQ_MSK) begin
      rd[2:0] = st_r.irq_msk;
    end else if (avm_req.address == `MECS_OFS_HCNT) begin
      rd[15:0] = st_r.hcnt;
    end else if (avm_req.address == `MECS_OFS_HPW) begin
      rd = st_r.hpw;
    end else if (avm_req.address == `MECS_OFS_HPR) begin
      rd = st_r.hpr;
    end else if (avm_req.address == `MECS_OFS_COEF) begin
      rd = st_r.coef;
    end else begin
      rd = '0; // unmapped reads return zero
    end
    if (avm_req.read & st_r.waitreq) begin
      st_nxt.rdata = rd;
    end

    // register writes at the taking edge; unmapped writes are dropped
    if (accept & avm_req.write) begin
      if (avm_req.address == `MECS_OFS_CFG) begin
        st_nxt.cfg = be_merge(st_r.cfg, avm_req.writedata, avm_req.byteenable)
          & `MECS_CFG_WMASK;
      end else if (avm_req.address == `MECS_OFS_THR) begin
        st_nxt.thr = be_merge(st_r.thr, avm_req.writedata, avm_req.byteenable);
      end else if (avm_req.address == `MECS_OFS_GAIN) begin
        if (st_r.cfg[`MECS_CFG_EXTT]) begin
          st_nxt.gain = be_merge(st_r.gain, avm_req.writedata, avm_req.byteenable);
        end
      end else if (avm_req.address == `MECS_OFS_IRQ_MSK) begin
        // the mask is three bits in the low lane, taken whole from the write data
        st_nxt.irq_msk = avm_req.writedata[2:0];
      end else if (avm_req.address == `MECS_OFS_HPW) begin
        st_nxt.hpw = be_merge(st_r.hpw, avm_req.writedata, avm_req.byteenable);
      end else if (avm_req.address == `MECS_OFS_HPR) begin
        st_nxt.hpr = be_merge(st_r.hpr, avm_req.writedata, avm_req.byteenable);
      end else if (avm_req.address == `MECS_OFS_COEF) begin
        st_nxt.coef = be_merge(st_r.coef, avm_req.writedata, avm_req.byteenable);
      end
    end

    // internal temperature compensation; host writes are ignored meanwhile
    if (temp_valid & ~st_r.cfg[`MECS_CFG_EXTT]) begin
      p1 = 24'(lin * temp_delta);
      sq = 16'(temp_delta * temp_delta);
      p2 = 32'(quad * sq);
      corr = 33'(p1) + 33'(p2);
      st_nxt.gain = `MECS_RST_GAIN + 32'(corr >>> `MECS_TC_SH);
    end

    // phase selection; codes with the high bit set fall back to phase A
    st_nxt.sel_b = ~st_r.cfg[`MECS_CFG_FS_HI] & st_r.cfg[`MECS_CFG_FS_LO];
    sel_sq = st_r.sel_b ? vb_square : va_square;
    st_nxt.sq_d = sel_sq;
    st_nxt.f0 = sel_sq;
    if (sel_sq != st_r.sq_d) begin
      st_nxt.hcnt = st_r.hcnt + 16'h0001; // half cycles counted on each edge
    end

    // sag events: rising edges of the combined and per-phase flags
    st_nxt.comb_d = sag_comb;
    st_nxt.sag_a_d = sag_a;
    st_nxt.sag_b_d = sag_b;
    ev[`MECS_IRQ_SAG] = sag_comb & ~st_r.comb_d;
    ev[`MECS_IRQ_SAGA] = sag_a & ~st_r.sag_a_d;
    ev[`MECS_IRQ_SAGB] = sag_b & ~st_r.sag_b_d;
    // read clears only the bits it reported; an event arriving meanwhile survives
    if (accept & avm_req.read & (avm_req.address == `MECS_OFS_IRQ_ST)) begin
      st_nxt.irq_st = (st_r.irq_st & ~st_r.rdata[2:0]) | ev;
    end else begin
      st_nxt.irq_st = st_r.irq_st | ev;
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);

    // auxiliary pin carries either the sag interrupt or its pulse function
    st_nxt.aux = st_r.cfg[`MECS_CFG_SAGINT] ? sag_comb : aux_pulse_in;

    // pulse generator source and scaling
    if (st_r.cfg[`MECS_CFG_EXTP]) begin
      src_w = st_r.hpw;
      src_r = st_r.hpr;
      src_v = '0;
    end else begin
      src_w = watt_sum;
      src_r = var_sum;
      src_v = va_sum;
    end
    if (st_r.cfg[`MECS_CFG_FAST]) begin
      st_nxt.pw = src_w << `MECS_FAST_SH;
      st_nxt.pr = src_r << `MECS_FAST_SH;
      st_nxt.pv = src_v << `MECS_FAST_SH;
      st_nxt.pgain = `MECS_PG_FAST;
    end else if (st_r.cfg[`MECS_CFG_SLOW]) begin
      st_nxt.pw = 32'($signed(src_w) >>> `MECS_SLOW_SH);
      st_nxt.pr = 32'($signed(src_r) >>> `MECS_SLOW_SH);
      st_nxt.pv = 32'($signed(src_v) >>> `MECS_SLOW_SH);
      st_nxt.pgain = `MECS_PG_SLOW;
    end else begin
      st_nxt.pw = src_w;
      st_nxt.pr = src_r;
      st_nxt.pv = src_v;
      st_nxt.pgain = `MECS_PG_NORM;
    end

    // shunt gains per current channel
    st_nxt.ga = st_r.cfg[`MECS_CFG_ASH] ? `MECS_GAIN_X8 : `MECS_GAIN_X1;
    st_nxt.gb = st_r.cfg[`MECS_CFG_BSH] ? `MECS_GAIN_X8 : `MECS_GAIN_X1;
  end

  // state register; derived outputs reset to the values the reset config implies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
      st_r.cfg <= `MECS_RST_CFG;
      st_r.thr <= `MECS_RST_THR;
      st_r.gain <= `MECS_RST_GAIN;
      st_r.pgain <= `MECS_PG_NORM;
      st_r.ga <= `MECS_GAIN_X1;
      st_r.gb <= `MECS_GAIN_X1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign avm_readdata = st_r.rdata;
  assign avm_waitrequest = st_r.waitreq;
  assign aux_pulse_pin = st_r.aux;
  assign irq = st_r.irq;
  assign phase_sel_b = st_r.sel_b;
  assign fundamental_square_flag = st_r.f0;
  assign gain_scale = st_r.gain;
  assign pulse_watt_in = st_r.pw;
  assign pulse_var_in = st_r.pr;
  assign pulse_va_in = st_r.pv;
  assign pulse_gain_q8 = st_r.pgain;
  assign chan_a_gain = st_r.ga;
  assign chan_b_gain = st_r.gb;

  chk_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
    req && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");
  chk_host_gain: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg[`MECS_CFG_EXTT] && !(accept && avm_req.write
      && avm_req.address == `MECS_OFS_GAIN) |=> $stable(gain_scale))
    else $error("gain scale moved under host compensation");
  chk_phase_pick: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> phase_sel_b == ($past(st_r.cfg[7:6]) == 2'b01))
    else $error("phase select decode wrong");
  chk_sag_route: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg[`MECS_CFG_SAGINT] |=> aux_pulse_pin == $past(sag_comb))
    else $error("sag interrupt not on auxiliary pin");
  chk_sag_all: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg[`MECS_CFG_SAGINT] && st_r.cfg[`MECS_CFG_SAGA] && st_r.cfg[`MECS_CFG_SAGB]
      && !(sag_a && sag_b) |=> !aux_pulse_pin)
    else $error("combined sag raised without both phases");
  chk_shunt_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> chan_a_gain == ($past(st_r.cfg[`MECS_CFG_ASH]) ? 4'h8 : 4'h1))
    else $error("channel A gain wrong");
  chk_shunt_b: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> chan_b_gain == ($past(st_r.cfg[`MECS_CFG_BSH]) ? 4'h8 : 4'h1))
    else $error("channel B gain wrong");
  chk_pulse_fast: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg[1:0] == 2'b10 |=> pulse_gain_q8 == 16'h6000 && pulse_watt_in[3:0] == 4'h0)
    else $error("fast pulse gain wrong");
  chk_pulse_src: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg[`MECS_CFG_EXTP] && st_r.cfg[1:0] == 2'b00 |=> pulse_watt_in == $past(st_r.hpw))
    else $error("host pulse value not used");
endmodule // mecs_top

// >>> verif/mecs_host_model.sv
`timescale 1ns/1ps
`include "mecs_defines.svh"
module mecs_host_model import mecs_pkg::*; (
  input wire logic core_clk,
  input wire logic avm_waitrequest,
  input wire logic [31:0] avm_readdata,
  output mecs_avm_req_s avm_req
);
  initial avm_req = '0;

  // one access; the request stands until waitrequest is sampled low at an edge
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    avm_req.read <= ~wr;
    avm_req.write <= wr;
    avm_req.address <= a;
    avm_req.byteenable <= 4'hF;
    // a real host never asks for both pulse gains at once
    avm_req.writedata <= (a == `MECS_OFS_CFG && d[1]) ? {d[31:1], 1'b0} : d;
    do @(posedge core_clk); while (avm_waitrequest !== 1'b0);
    q = avm_readdata;
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
    // idle bus shows a changed pattern, so a stale copy is never mistaken for a request
    avm_req.address <= ~a;
    avm_req.writedata <= ~d;
  endtask
endmodule // mecs_host_model

// >>> verif/mecs_top_tb.sv
`timescale 1ns/1ps
`include "mecs_defines.svh"
module mecs_top_tb import mecs_pkg::*;;
  localparam logic [31:0] hw_val = 32'h0000_0200;
  localparam logic [31:0] hr_val = 32'hFFFF_FE00;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  mecs_avm_req_s avm_req;
  logic smp_valid = 1'b0, va_square = 1'b0, vb_square = 1'b1, temp_valid = 1'b0;
  logic aux_pulse_in = 1'b1;
  logic [31:0] va_mag = '0, vb_mag = '0;
  logic signed [7:0] temp_delta = '0;
  logic [31:0] watt_sum = 32'h0000_1000, var_sum = 32'hFFFF_F000, va_sum = 32'h0000_0100;
  logic avm_waitrequest, aux_pulse_pin, irq, phase_sel_b, fundamental_square_flag;
  logic [31:0] avm_readdata, gain_scale, pulse_watt_in, pulse_var_in, pulse_va_in;
  logic [15:0] pulse_gain_q8;
  logic [3:0] chan_a_gain, chan_b_gain;
  int err_total = 0;
  int check_count = 0;

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  mecs_top DUT (.core_clk, .rst, .avm_req, .avm_readdata, .avm_waitrequest, .smp_valid,
    .va_mag, .vb_mag, .va_square, .vb_square, .temp_valid, .temp_delta, .watt_sum,
    .var_sum, .va_sum, .aux_pulse_in, .aux_pulse_pin, .irq, .phase_sel_b,
    .fundamental_square_flag, .gain_scale, .pulse_watt_in, .pulse_var_in, .pulse_va_in,
    .pulse_gain_q8, .chan_a_gain, .chan_b_gain);
  mecs_host_model u_host (.core_clk, .avm_waitrequest, .avm_readdata, .avm_req);

  // shared compare, bus and stimulus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // registered outputs need a few edges; #1 keeps sampling clear of the edge
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic smp(input logic [31:0] a, input logic [31:0] b, input int n);
    repeat (n) begin
      @(posedge core_clk);
      va_mag <= a;
      vb_mag <= b;
      smp_valid <= 1'b1;
      @(posedge core_clk);
      smp_valid <= 1'b0;
    end
  endtask
  task automatic tmp(input logic [7:0] d);
    @(posedge core_clk);
    temp_delta <= d;
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    settle();
  endtask
  // fast shifts up by four, slow is an arithmetic shift down by six
  function automatic logic [31:0] scl(input logic [31:0] x, input logic [7:0] c);
    logic signed [31:0] y;
    y = x;
    y = y >>> 6;
    if (c[1]) return x << 4;
    if (c[0]) return y;
    return x;
  endfunction

  task automatic t_reset;
    chk(chan_a_gain, 32'h1);
    chk(chan_b_gain, 32'h1);
    chk(pulse_gain_q8, 32'h0600);
    chk(gain_scale, 32'h0000_4000);
    chk(aux_pulse_pin, aux_pulse_in);
    chk(pulse_watt_in, 32'h0);
    rd(`MECS_OFS_CFG, 32'h0000_5020);
    rd(`MECS_OFS_THR, 32'h0006_C278);
  endtask

  // every writable bit but the slow bit set: unused bits drop, count reaches its maximum
  task automatic t_cfg_bits;
    wr(`MECS_OFS_CFG, 32'hFFFF_FFFE);
    rd(`MECS_OFS_CFG, 32'h000F_FFEE);
    settle();
    chk(chan_a_gain, 32'h8);
    chk(pulse_gain_q8, 32'h6000);
    chk(phase_sel_b, 32'h0);
  endtask

  task automatic t_pulse;
    logic [7:0] tbl [0:6] = '{8'h00, 8'h02, 8'h01, 8'h04, 8'h08, 8'h40, 8'h20};
    logic [31:0] s [0:2];
    wr(`MECS_OFS_HPW, hw_val);
    wr(`MECS_OFS_HPR, hr_val);
    foreach (tbl[i]) begin
      wr(`MECS_OFS_CFG, {24'h0, tbl[i]});
      settle();
      if (tbl[i][5]) begin
        s = '{hw_val, hr_val, 32'h0};
      end else begin
        s = '{watt_sum, var_sum, va_sum};
      end
      chk(pulse_watt_in, scl(s[0], tbl[i]));
      chk(pulse_var_in, scl(s[1], tbl[i]));
      chk(pulse_va_in, scl(s[2], tbl[i]));
      chk(pulse_gain_q8, tbl[i][1] ? 32'h6000 : tbl[i][0] ? 32'h0018 : 32'h0600);
      chk(chan_a_gain, tbl[i][2] ? 32'h8 : 32'h1);
      chk(chan_b_gain, tbl[i][3] ? 32'h8 : 32'h1);
      chk(phase_sel_b, tbl[i][7:6] == 2'b01);
      chk(fundamental_square_flag, tbl[i][7:6] == 2'b01 ? vb_square : va_square);
    end
  endtask

  // count of three; a sample equal to the threshold restarts the count
  task automatic t_sag;
    wr(`MECS_OFS_THR, 32'h0000_0064);
    wr(`MECS_OFS_IRQ_MSK, 32'h1);
    wr(`MECS_OFS_CFG, 32'h0004_0320);
    smp(32'h32, 32'hC8, 2);
    rd(`MECS_OFS_STAT, 32'h0);
    smp(32'h64, 32'hC8, 1);
    smp(32'h32, 32'hC8, 2);
    rd(`MECS_OFS_STAT, 32'h0);
    smp(32'h32, 32'hC8, 1);
    rd(`MECS_OFS_STAT, 32'h0200_0000);
    settle();
    chk(irq, 32'h1);
    rd(`MECS_OFS_IRQ_ST, 32'h3);
    rd(`MECS_OFS_IRQ_ST, 32'h0);
    wr(`MECS_OFS_CFG, 32'h000E_0320);
    settle();
    chk(irq, 32'h0);
    chk(aux_pulse_pin, 32'h0);
    wr(`MECS_OFS_IRQ_MSK, 32'h0);
    smp(32'h32, 32'h32, 3);
    settle();
    chk(aux_pulse_pin, 32'h1);
    chk(irq, 32'h0);
    wr(`MECS_OFS_IRQ_MSK, 32'h4);
    settle();
    chk(irq, 32'h1);
    rd(`MECS_OFS_IRQ_ST, 32'h5);
    settle();
    chk(irq, 32'h0);
    smp(32'hC8, 32'h32, 1);
    rd(`MECS_OFS_STAT, 32'h0400_0000);
    settle();
    chk(aux_pulse_pin, 32'h0);
  endtask

  // engine owns the gain until the host takes it over
  task automatic t_gain;
    wr(`MECS_OFS_CFG, 32'h0000_0020);
    wr(`MECS_OFS_GAIN, 32'h0000_1234);
    rd(`MECS_OFS_GAIN, 32'h0000_4000);
    wr(`MECS_OFS_COEF, 32'h0001_4000);
    tmp(8'h02);
    rd(`MECS_OFS_GAIN, 32'h0000_4002);
    tmp(8'hFE);
    chk(gain_scale, 32'h0000_3FFE);
    wr(`MECS_OFS_CFG, 32'h0001_0020);
    wr(`MECS_OFS_GAIN, 32'h0000_1234);
    tmp(8'h02);
    rd(`MECS_OFS_GAIN, 32'h0000_1234);
    wr(9'h1F0, 32'hFFFF_FFFF);
    rd(9'h1F0, 32'h0);
  endtask

  // phase A edges feed the half-cycle count and square flag; aux follows its own input
  task automatic t_edges;
    logic [31:0] q0;
    wr(`MECS_OFS_CFG, 32'h0000_0020);
    aux_pulse_in <= 1'b0;
    u_host.xfer(1'b0, `MECS_OFS_HCNT, 32'h0, q0);
    repeat (3) begin
      @(posedge core_clk);
      va_square <= ~va_square;
      settle();
    end
    rd(`MECS_OFS_HCNT, q0 + 32'h3);
    rd(`MECS_OFS_STAT, 32'h1400_0000);
    chk(aux_pulse_pin, 32'h0);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence after five cycles of reset
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_cfg_bits();
    t_pulse();
    t_sag();
    t_gain();
    t_edges();
    summarize();
  end

  // the run needs about two hundred cycles; a hundred times that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("[FAIL] %0t: watchdog expired", $time);
    summarize();
  end
endmodule // mecs_top_tb
